// ===== common/spb_serial_map.vh
// Register map, field positions and reset values of the serial port
// Assumes an APB bus with 32-bit data and byte addressing
`ifndef SPB_SERIAL_MAP_VH
`define SPB_SERIAL_MAP_VH

// Word offsets
`define SPB_ADDR_BUFFER   12'h000
`define SPB_ADDR_CTRL     12'h004
`define SPB_ADDR_POWER    12'h008
`define SPB_ADDR_T2CTRL   12'h00C
`define SPB_ADDR_T2RELOAD 12'h010

// serial_ctrl_reg fields
`define SPB_CTRL_MODE_HI  7
`define SPB_CTRL_MODE_LO  6
`define SPB_CTRL_MPF      5
`define SPB_CTRL_RXEN     4
`define SPB_CTRL_TX9      3
`define SPB_CTRL_RX9      2
`define SPB_CTRL_TXDONE   1
`define SPB_CTRL_RXDONE   0

// power_ctrl_reg field
`define SPB_POWER_DOUBLER 7

// timer_two_ctrl fields
`define SPB_T2_EXTFLAG    6
`define SPB_T2_RXCLK      5
`define SPB_T2_TXCLK      4
`define SPB_T2_EXTEN      3
`define SPB_T2_RUN        2

// Reset values
`define SPB_RST_BYTE      8'h00
`define SPB_RST_WORD      16'h0000

// Timing
`define SPB_MCYCLE_LAST   4'd11
`define SPB_SCLK_RISE     4'd6
`define SPB_SAMPLE_A      4'd7
`define SPB_SAMPLE_C      4'd9

`endif

// ===== rtl/spb_serial_port.v
// Full-duplex serial port with four modes, multiprocessor filter and a timer 2 baud generator
// Assumes pclk is the oscillator clock, an APB master on the bus side and timer 1 overflow as a pclk pulse
//
// Overview of operation
// - Transmit and receive run concurrently, but mode 0 receive waits for transmit; unread byte blocks next
// - Buffer write feeds transmitter; read returns receive register
// - Mode 0: data on bidir pin, shift clock out
// - Mode 1: start, eight data, stop into ninth
// - Modes 2/3: ninth bit sent, received ninth stored
// - Mode 2 rate osc/64, or osc/32 doubled
// - Mode 3 frames like mode 2, timer rate
// - Buffer write always starts a transmission
// - Mode 0 receive starts on enable, flag clear
// - Async receive starts on start bit when enabled
// - Filter: modes 2/3 flag only ninth set
// - Filter ignored mode 0; mode 1 needs stop
// - Modes 1/3 clocked by timer 1 or 2
// - Timer 1 rate: 2^doubler/32 of overflows
// - Timer 2 control codes select tx/rx clocking
// - Baud codes carry run bit already
// - Trigger pin never reloads timer 2 here
// - Timer 2 counts state times, silent reload
// - Receiver oversamples x16, realigns on falling edge
// - Final shift, release frame, set transmit flag
module spb_serial_port (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        timer_one_overflow,
    input  wire        timer_two_trigger_pin,
    input  wire        serial_in_pin_i,
    output reg         serial_in_pin_o,
    output reg         serial_in_pin_oe_n,
    output reg         serial_out_pin,
    output reg         serial_irq
);
`include "spb_serial_map.vh"

localparam [2:0] TX_IDLE = 3'b001;
localparam [2:0] TX_SEND = 3'b010;
localparam [2:0] TX_DONE = 3'b100;

function maj3;
    input [2:0] v;
    begin
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers and pin synchronisers
reg  [7:0]  ctrl_q;
reg  [7:0]  power_q;
reg  [7:0]  t2ctrl_q;
reg  [15:0] t2reload_q;
reg  [15:0] t2cnt_q;
reg  [7:0]  rxbuf_q;
reg         rxd_s1_q, rxd_s2_q, rxd_s3_q;
reg         trg_s1_q, trg_s2_q, trg_s3_q;

wire [1:0] mode    = {ctrl_q[`SPB_CTRL_MODE_HI], ctrl_q[`SPB_CTRL_MODE_LO]};
wire       mode0   = (mode == 2'd0);
wire       doubler = power_q[`SPB_POWER_DOUBLER];
wire       acc     = psel & penable & pready;
wire       wr_ev   = acc & pwrite;
wire       wr_buf  = wr_ev & (paddr == `SPB_ADDR_BUFFER);
wire       wr_ctrl = wr_ev & (paddr == `SPB_ADDR_CTRL);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rxd_s1_q <= 1'b1;
        rxd_s2_q <= 1'b1;
        rxd_s3_q <= 1'b1;
        trg_s1_q <= 1'b1;
        trg_s2_q <= 1'b1;
        trg_s3_q <= 1'b1;
    end else begin
        rxd_s1_q <= serial_in_pin_i;
        rxd_s2_q <= rxd_s1_q;
        rxd_s3_q <= rxd_s2_q;
        trg_s1_q <= timer_two_trigger_pin;
        trg_s2_q <= trg_s1_q;
        trg_s3_q <= trg_s2_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Baud sources
reg  [3:0] mc_q;
reg  [1:0] pre_q;
reg        st_q;
reg        t1_half_q;
wire       mc_tick = (mc_q == `SPB_MCYCLE_LAST);
wire       t2_on   = t2ctrl_q[`SPB_T2_RUN] & (t2ctrl_q[`SPB_T2_RXCLK] | t2ctrl_q[`SPB_T2_TXCLK]);
wire       t2_ovf  = t2_on & st_q & (t2cnt_q == 16'hFFFF);
wire       t1_tick = timer_one_overflow & (doubler | t1_half_q);
wire       m2_tick = doubler ? pre_q[0] : (pre_q == 2'd3);
wire       tx16 = (mode == 2'd2) ? m2_tick : (t2ctrl_q[`SPB_T2_TXCLK] ? t2_ovf : t1_tick);
wire       rx16 = (mode == 2'd2) ? m2_tick : (t2ctrl_q[`SPB_T2_RXCLK] ? t2_ovf : t1_tick);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mc_q      <= 4'd0;
        pre_q     <= 2'd0;
        st_q      <= 1'b0;
        t1_half_q <= 1'b0;
        t2cnt_q   <= `SPB_RST_WORD;
    end else begin
        mc_q      <= mc_tick ? 4'd0 : mc_q + 4'd1;
        pre_q     <= pre_q + 2'd1;
        st_q      <= ~st_q;
        t1_half_q <= t1_half_q ^ timer_one_overflow;
        // The counter has no bus access of its own, so a reload write presets it too
        if (wr_ev & (paddr == `SPB_ADDR_T2RELOAD)) begin
            t2cnt_q <= pwdata[15:0];
        end else if (t2_on & st_q) begin
            t2cnt_q <= t2_ovf ? t2reload_q : t2cnt_q + 16'd1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Transmitter
reg  [2:0]  tx_st_q;
reg  [10:0] tx_sh_q;
reg  [3:0]  tx_bits_q;
reg  [3:0]  tx_div_q;
reg         tx_m0_q;
reg         txd_q;
wire        tx_bit = tx_m0_q ? mc_tick : (tx16 & (tx_div_q == 4'hF));
wire        tx_set = (tx_st_q == TX_DONE);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_st_q   <= TX_IDLE;
        tx_sh_q   <= 11'h7FF;
        tx_bits_q <= 4'd0;
        tx_div_q  <= 4'd0;
        tx_m0_q   <= 1'b0;
        txd_q     <= 1'b1;
    end else begin
        if (tx16) begin
            tx_div_q <= tx_div_q + 4'd1;
        end
        if (wr_buf) begin
            tx_st_q <= TX_SEND;
            tx_m0_q <= mode0;
            case (mode)
                2'd0: begin
                    tx_sh_q   <= {3'b111, pwdata[7:0]};
                    tx_bits_q <= 4'd8;
                end
                2'd1: begin
                    tx_sh_q   <= {2'b11, pwdata[7:0], 1'b0};
                    tx_bits_q <= 4'd10;
                end
                default: begin
                    tx_sh_q   <= {1'b1, ctrl_q[`SPB_CTRL_TX9], pwdata[7:0], 1'b0};
                    tx_bits_q <= 4'd11;
                end
            endcase
        end else begin
            case (tx_st_q)
                TX_SEND: begin
                    if (tx_bit) begin
                        if (tx_bits_q == 4'd0) begin
                            tx_st_q <= TX_DONE;
                            txd_q   <= 1'b1;
                        end else begin
                            txd_q     <= tx_sh_q[0];
                            tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                            tx_bits_q <= tx_bits_q - 4'd1;
                        end
                    end
                end
                TX_DONE: tx_st_q <= TX_IDLE;
                TX_IDLE: tx_st_q <= TX_IDLE;
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Receiver
reg         rx_busy_q;
reg         rx_m0_q;
reg  [3:0]  rx_div_q;
reg  [3:0]  rx_bits_q;
reg  [10:0] rx_sh_q;
reg  [1:0]  rx_vote_q;
reg         rx_done_q;
reg         rx_ok_q;
reg  [7:0]  rx_data_q;
reg         rx_ninth_q;
// Pins stay idle until a machine-cycle boundary puts bit 0 out, so no clock pulse carries stale data
wire        tx0_busy = tx_m0_q & (tx_st_q == TX_SEND) & (tx_bits_q != 4'd8);
wire        rx_bit   = maj3({rx_vote_q, rxd_s2_q});
wire [3:0]  rx_total = (mode == 2'd1) ? 4'd10 : 4'd11;
wire        rx_fall  = rxd_s3_q & ~rxd_s2_q;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rx_busy_q  <= 1'b0;
        rx_m0_q    <= 1'b0;
        rx_div_q   <= 4'd0;
        rx_bits_q  <= 4'd0;
        rx_sh_q    <= 11'h7FF;
        rx_vote_q  <= 2'b11;
        rx_done_q  <= 1'b0;
        rx_ok_q    <= 1'b0;
        rx_data_q  <= `SPB_RST_BYTE;
        rx_ninth_q <= 1'b0;
    end else begin
        rx_done_q <= 1'b0;
        if (!rx_busy_q) begin
            if (mode0 & ctrl_q[`SPB_CTRL_RXEN] & ~ctrl_q[`SPB_CTRL_RXDONE] & ~tx0_busy & mc_tick) begin
                rx_busy_q <= 1'b1;
                rx_m0_q   <= 1'b1;
                rx_bits_q <= 4'd0;
            end else if (~mode0 & ctrl_q[`SPB_CTRL_RXEN] & rx_fall) begin
                rx_busy_q <= 1'b1;
                rx_m0_q   <= 1'b0;
                rx_div_q  <= 4'd0;
                rx_bits_q <= 4'd0;
            end
        end else if (rx_m0_q) begin
            if (mc_tick) begin
                rx_sh_q   <= {rxd_s2_q, rx_sh_q[10:1]};
                rx_bits_q <= rx_bits_q + 4'd1;
                if (rx_bits_q == 4'd7) begin
                    rx_busy_q <= 1'b0;
                    rx_done_q <= 1'b1;
                    rx_ok_q   <= 1'b1;
                    rx_data_q <= {rxd_s2_q, rx_sh_q[10:4]};
                end
            end
        end else if (rx16) begin
            rx_div_q <= rx_div_q + 4'd1;
            if (rx_div_q >= `SPB_SAMPLE_A && rx_div_q < `SPB_SAMPLE_C) begin
                rx_vote_q <= {rx_vote_q[0], rxd_s2_q};
            end
            if (rx_div_q == `SPB_SAMPLE_C) begin
                if (rx_bits_q == 4'd0 && rx_bit) begin
                    rx_busy_q <= 1'b0;
                end else begin
                    rx_sh_q   <= {rx_bit, rx_sh_q[10:1]};
                    rx_bits_q <= rx_bits_q + 4'd1;
                    if (rx_bits_q == rx_total - 4'd1) begin
                        rx_busy_q <= 1'b0;
                        rx_done_q <= 1'b1;
                        if (mode == 2'd1) begin
                            rx_data_q  <= rx_sh_q[10:3];
                            rx_ninth_q <= rx_bit;
                            rx_ok_q    <= ~ctrl_q[`SPB_CTRL_MPF] | rx_bit;
                        end else begin
                            rx_data_q  <= rx_sh_q[9:2];
                            rx_ninth_q <= rx_sh_q[10];
                            rx_ok_q    <= ~ctrl_q[`SPB_CTRL_MPF] | rx_sh_q[10];
                        end
                    end
                end
            end
        end
    end
end

wire rx_take = rx_done_q & rx_ok_q & ~ctrl_q[`SPB_CTRL_RXDONE];

////////////////////////////////////////////////////////////////////////////////
// Software registers
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_q     <= `SPB_RST_BYTE;
        power_q    <= `SPB_RST_BYTE;
        t2ctrl_q   <= `SPB_RST_BYTE;
        t2reload_q <= `SPB_RST_WORD;
        rxbuf_q    <= `SPB_RST_BYTE;
    end else begin
        if (wr_ctrl) begin
            ctrl_q[7:2] <= pwdata[7:2];
        end
        ctrl_q[`SPB_CTRL_TXDONE] <= tx_set | (wr_ctrl ? pwdata[`SPB_CTRL_TXDONE] : ctrl_q[`SPB_CTRL_TXDONE]);
        ctrl_q[`SPB_CTRL_RXDONE] <= rx_take | (wr_ctrl ? pwdata[`SPB_CTRL_RXDONE] : ctrl_q[`SPB_CTRL_RXDONE]);
        if (rx_take) begin
            rxbuf_q <= rx_data_q;
            if (!rx_m0_q) begin
                ctrl_q[`SPB_CTRL_RX9] <= rx_ninth_q;
            end
        end
        if (wr_ev & (paddr == `SPB_ADDR_POWER)) begin
            power_q <= pwdata[7:0];
        end
        if (wr_ev & (paddr == `SPB_ADDR_T2CTRL)) begin
            t2ctrl_q <= pwdata[7:0];
        end
        // A trigger edge in the same cycle as a write still sets the flag
        if (t2ctrl_q[`SPB_T2_EXTEN] & trg_s3_q & ~trg_s2_q) begin
            t2ctrl_q[`SPB_T2_EXTFLAG] <= 1'b1;
        end
        if (wr_ev & (paddr == `SPB_ADDR_T2RELOAD)) begin
            t2reload_q <= pwdata[15:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB answer and pins
reg  [31:0] rd_mux;
reg         rd_bad;

always @* begin
    rd_bad = 1'b0;
    case (paddr)
        `SPB_ADDR_BUFFER:   rd_mux = {24'h00_0000, rxbuf_q};
        `SPB_ADDR_CTRL:     rd_mux = {24'h00_0000, ctrl_q};
        `SPB_ADDR_POWER:    rd_mux = {24'h00_0000, power_q};
        `SPB_ADDR_T2CTRL:   rd_mux = {24'h00_0000, t2ctrl_q};
        `SPB_ADDR_T2RELOAD: rd_mux = {16'h0000, t2reload_q};
        default: begin
            rd_mux = 32'h0000_0000;
            rd_bad = 1'b1;
        end
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata             <= 32'h0000_0000;
        pready             <= 1'b0;
        pslverr            <= 1'b0;
        serial_in_pin_o    <= 1'b1;
        serial_in_pin_oe_n <= 1'b1;
        serial_out_pin     <= 1'b1;
        serial_irq         <= 1'b0;
    end else begin
        pready  <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & rd_bad;
        prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
        serial_in_pin_o    <= tx0_busy ? txd_q : 1'b1;
        serial_in_pin_oe_n <= ~tx0_busy;
        if (tx0_busy | (rx_busy_q & rx_m0_q)) begin
            serial_out_pin <= (mc_q >= `SPB_SCLK_RISE);
        end else begin
            serial_out_pin <= mode0 | txd_q;
        end
        serial_irq <= ctrl_q[`SPB_CTRL_TXDONE] | ctrl_q[`SPB_CTRL_RXDONE];
    end
end

endmodule // spb_serial_port

// ===== verif/spb_serial_port_assertions.sv
// Checker on the serial port pins and APB answers
// Assumes binding to spb_serial_port; mode and doubler tracked from APB writes
`include "spb_serial_map.vh"
module spb_serial_port_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_in_pin_oe_n,
    input wire logic        serial_out_pin,
    input wire logic        serial_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  mode_q;
    logic        dbl_q;
    logic [11:0] low_q;
    wire         wr_w  = psel && penable && pready && pwrite;
    wire         map_w = (paddr <= `SPB_ADDR_T2RELOAD) && (paddr[1:0] == 2'b00);
    wire         ctl_w = wr_w && (paddr == `SPB_ADDR_CTRL);
    wire         buf_w = wr_w && (paddr == `SPB_ADDR_BUFFER);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    // Low run length of the transmit pin, in pclk cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'b00;
            dbl_q  <= 1'b0;
            low_q  <= 12'h000;
        end else begin
            if (ctl_w)
                mode_q <= pwdata[7:6];
            if (wr_w && (paddr == `SPB_ADDR_POWER))
                dbl_q <= pwdata[`SPB_POWER_DOUBLER];
            low_q <= serial_out_pin ? 12'h000 : low_q + 12'h001;
        end
    end
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("access not answered");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_decode; (pready || pslverr) |-> pready && (pslverr == !map_w); endproperty
    a_decode: assert property (p_decode) else $error("bad error response");
    property p_rdzero; !pready |-> prdata == 32'h0000_0000; endproperty
    a_rdzero: assert property (p_rdzero) else $error("read data outside answer");
    property p_irqfall; $fell(serial_irq) |-> $past(ctl_w) || $past(ctl_w, 2) || $past(ctl_w, 3); endproperty
    a_irqfall: assert property (p_irqfall) else $error("irq fell without flag clear");
    property p_oemode; !serial_in_pin_oe_n |-> mode_q == 2'b00; endproperty
    a_oemode: assert property (p_oemode) else $error("data pin driven outside mode 0");
    property p_m0clk; !serial_in_pin_oe_n && $fell(serial_out_pin) |-> !serial_out_pin [*6] ##1 serial_out_pin; endproperty
    a_m0clk: assert property (p_m0clk) else $error("shift clock low phase wrong");
    property p_bitlen;
        mode_q == 2'b10 && $rose(serial_out_pin) |-> (low_q != 12'h000) && ((low_q & (dbl_q ? 12'h01F : 12'h03F)) == 12'h000);
    endproperty
    a_bitlen: assert property (p_bitlen) else $error("mode 2 bit length wrong");
    property p_start; buf_w && !mode_q[0] |-> ##[1:160] (!serial_out_pin || !serial_in_pin_oe_n); endproperty
    a_start: assert property (p_start) else $error("buffer write started nothing");
    c_m0: cover property (!serial_in_pin_oe_n && $fell(serial_out_pin));
    c_err: cover property (pslverr);
    c_m2: cover property (mode_q == 2'b10 && $rose(serial_out_pin));
endmodule // spb_serial_port_checker

// ===== verif/spb_peer.sv
// Remote serial peer: sends and captures asynchronous frames
// Assumes whole-cycle bit periods and calls made just after a rising edge
module spb_peer (
    input  wire logic pclk,
    input  wire logic line_in,
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_byte = 8'h00;
    logic       got_ninth = 1'b0;
    initial line_out = 1'b1;
    task automatic send(input logic [7:0] b, input logic ninth, input int per);
        logic [10:0] fr;
        fr = {1'b1, ninth, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_out <= fr[i];
            repeat (per) @(posedge pclk);
        end
    endtask
    // Samples mid-bit after the start edge
    task automatic recv(input int per, input int nbits);
        for (int t = 0; t < 4000 && line_in !== 1'b0; t++)
            @(posedge pclk);
        repeat (per / 2) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
            repeat (per) @(posedge pclk);
            if (i < 8)
                got_byte[i] = line_in;
            else
                got_ninth = line_in;
        end
    endtask
    // Mode 0 source: puts the next bit out after each falling shift clock, then idles high
    task automatic shift_out(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            for (int t = 0; t < 100 && line_in !== 1'b0; t++)
                @(posedge pclk);
            line_out <= b[i];
            for (int t = 0; t < 100 && line_in !== 1'b1; t++)
                @(posedge pclk);
        end
        repeat (12) @(posedge pclk);
        line_out <= 1'b1;
    endtask
endmodule // spb_peer

// ===== verif/spb_serial_port_bench.sv
// Bench: APB master, remote peer on the line, random bytes with corner cases
// Assumes the peer and checker files are compiled before this one
`include "spb_serial_map.vh"
module spb_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] r;
    logic [7:0]  b;
    logic [7:0]  got;
    logic [7:0]  exp_buf;
    logic        er;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cyc = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, sin_o, sin_oe_n, sout, irq, peer_line;
    wire         sin_i = sin_oe_n ? peer_line : sin_o;
    logic [7:0]  t2code [3] = '{8'h34, 8'h24, 8'h14};
    logic [7:0]  c_ctl [4] = '{8'h88, 8'h88, 8'hC8, 8'h48};
    logic [7:0]  c_pow [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
    logic [7:0]  c_t2 [4] = '{8'h00, 8'h00, 8'h14, 8'h00};
    int          c_per [4] = '{64, 32, 128, 384};
    logic        trig = 1'b1;
    logic        t1_ovf = 1'b0;
    int          t1_cnt = 0;
    spb_serial_port spb_serial_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_one_overflow(t1_ovf), .timer_two_trigger_pin(trig), .serial_in_pin_i(sin_i),
        .serial_in_pin_o(sin_o), .serial_in_pin_oe_n(sin_oe_n), .serial_out_pin(sout), .serial_irq(irq));
    spb_peer spb_peer_inst (.pclk(pclk), .line_in(sout), .line_out(peer_line));
    ////////////////////////////////////////////////////////////
    always #2.5 pclk = ~pclk;
    // Timer 1 in 8-bit auto-reload with an all-ones reload: one overflow per machine cycle, interrupt unused
    always @(posedge pclk) begin
        t1_cnt <= (t1_cnt == 11) ? 0 : t1_cnt + 1;
        t1_ovf <= (t1_cnt == 11);
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] w8(input logic [7:0] x);
        return {24'h00_0000, x};
    endfunction
    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string what);
        compares++;
        if (got_v !== exp_v) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got_v, exp_v);
        end
    endtask
    task automatic chk1(input logic got_v, input logic exp_v, input string what);
        chk({31'h0, got_v}, {31'h0, exp_v}, what);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for the interrupt, checks the transmit flag, then clears the control register
    task automatic tx_done();
        for (int i = 0; i < 3000 && irq !== 1'b1; i++)
            @(posedge pclk);
        chk1(irq, 1'b1, "irq");
        apb(1'b0, `SPB_ADDR_CTRL, 32'h0000_0000);
        chk1(rd[`SPB_CTRL_TXDONE], 1'b1, "tx flag");
        apb(1'b1, `SPB_ADDR_CTRL, 32'h0000_0000);
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(37));
        repeat (4) @(posedge pclk);
        chk1(sout & sin_oe_n & sin_o & !irq & !pready, 1'b1, "reset pins");
        presetn <= 1'b1;
        apb(1'b0, `SPB_ADDR_POWER, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "doubler reset");
        r = $urandom;
        apb(1'b1, `SPB_ADDR_T2RELOAD, r);
        apb(1'b0, `SPB_ADDR_T2RELOAD, 32'h0000_0000);
        chk(rd, {16'h0000, r[15:0]}, "reload");
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk1(er, 1'b1, "unmapped");
        foreach (t2code[i]) begin
            apb(1'b1, `SPB_ADDR_T2CTRL, w8(t2code[i]));
            apb(1'b0, `SPB_ADDR_T2CTRL, 32'h0000_0000);
            chk(rd, w8(t2code[i]), "timer two code");
        end
        b = 8'($urandom);
        apb(1'b1, `SPB_ADDR_BUFFER, w8(b));
        for (int i = 0; i < 8; i++) begin
            for (int t = 0; t < 100 && !(sout === 1'b0 && sin_oe_n === 1'b0); t++)
                @(posedge pclk);
            for (int t = 0; t < 100 && sout !== 1'b1; t++)
                @(posedge pclk);
            got[i] = sin_o;
        end
        chk(w8(got), w8(b), "shift byte");
        tx_done();
        apb(1'b1, `SPB_ADDR_T2RELOAD, 32'h0000_FFFC);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            apb(1'b1, `SPB_ADDR_POWER, w8(c_pow[i]));
            apb(1'b1, `SPB_ADDR_T2CTRL, w8(c_t2[i]));
            apb(1'b1, `SPB_ADDR_CTRL, w8(c_ctl[i]));
            fork
                spb_peer_inst.recv(c_per[i], 9);
                apb(1'b1, `SPB_ADDR_BUFFER, w8(b));
            join
            chk(w8(spb_peer_inst.got_byte), w8(b), "frame byte");
            chk1(spb_peer_inst.got_ninth, 1'b1, "frame ninth");
            tx_done();
        end
        b = 8'($urandom);
        fork
            spb_peer_inst.shift_out(b);
            apb(1'b1, `SPB_ADDR_CTRL, 32'h0000_0010);
        join
        apb(1'b0, `SPB_ADDR_BUFFER, 32'h0000_0000);
        chk(rd, w8(b), "shift in byte");
        apb(1'b1, `SPB_ADDR_T2CTRL, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            apb(1'b1, `SPB_ADDR_CTRL, w8(8'h90 | (i > 0 ? 8'h20 : 8'h00) | (i == 3 ? 8'h01 : 8'h00)));
            fork
                spb_peer_inst.send(b, i > 1, 64);
                begin
                    apb(1'b1, `SPB_ADDR_BUFFER, w8(~b));
                    spb_peer_inst.recv(64, 9);
                    repeat (128) @(posedge pclk);
                end
            join
            if (i == 0 || i == 2)
                exp_buf = b;
            apb(1'b0, `SPB_ADDR_CTRL, 32'h0000_0000);
            chk1(rd[`SPB_CTRL_RXDONE], i != 1, "rx flag");
            chk1(rd[`SPB_CTRL_TXDONE], 1'b1, "tx beside rx");
            if (i % 2 == 0)
                chk1(rd[`SPB_CTRL_RX9], i == 2, "rx ninth");
            apb(1'b0, `SPB_ADDR_BUFFER, 32'h0000_0000);
            chk(rd, w8(exp_buf), "rx byte");
            chk(w8(spb_peer_inst.got_byte), w8(~b), "tx byte");
        end
        apb(1'b1, `SPB_ADDR_T2CTRL, 32'h0000_001C);
        trig <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, `SPB_ADDR_T2CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_005C, "trigger flag");
        apb(1'b0, `SPB_ADDR_T2RELOAD, 32'h0000_0000);
        chk(rd, 32'h0000_FFFC, "no trigger reload");
        tally_and_finish();
    end
endmodule // spb_serial_port_bench
bind spb_serial_port spb_serial_port_checker spb_serial_port_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin_oe_n(serial_in_pin_oe_n),
    .serial_out_pin(serial_out_pin), .serial_irq(serial_irq));
